// ### hw/rll_endec_pkg.sv
`default_nettype none
package rll_endec_pkg;

  // ==========================================================================
  // Pin bundle as seen after synchronisation
  typedef struct packed {
    logic       read_gate_n;
    logic       write_gate_n;
    logic       addr_mark_enable_n;
    logic       sync_pattern_latch_n;
    logic       precomp_latch_n;
    logic       window_shift_latch_n;
    logic [2:0] shift_sel_n;          // shift_sel_bit2_n..shift_sel_bit0_n
    logic       window_shift_dir;
    logic       phase_detect_enable;
    logic       host_data_parity;
    logic [7:0] host_data_bus;
    logic       write_clock;
    logic       ref_oscillator;
    logic       recovered_byte_clock_src;
    logic       recovered_half_clock_src;
  } pin_t;

  // Idle level of every pin: gates and latch controls high
  localparam pin_t PINS_IDLE = '{read_gate_n: 1'b1, write_gate_n: 1'b1,
    addr_mark_enable_n: 1'b1, sync_pattern_latch_n: 1'b1, precomp_latch_n: 1'b1,
    window_shift_latch_n: 1'b1, shift_sel_n: 3'h7, window_shift_dir: 1'b1,
    phase_detect_enable: 1'b1, default: '0};

  // Byte plus parity on the host port
  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } host_word_t;

  // Queued write byte; mark is set from the sync byte onward
  typedef struct packed {
    logic       mark;
    logic [7:0] data;
  } queued_byte_t;

  // Latched shift settings (active high magnitudes)
  typedef struct packed {
    logic [2:0] mag;
    logic       dir;
  } shift_cfg_t;

  // ==========================================================================
  // Write sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    WR_IDLE   = 3'h0,
    WR_WAIT   = 3'h1,
    WR_AMARK  = 3'h3,
    WR_PREAMB = 3'h2,
    WR_DATA   = 3'h6
  } wr_state_t;

  // ==========================================================================
  // Channel framing
  localparam int         CH_PER_BYTE   = 12;           // ref oscillator rises per byte
  localparam logic [3:0] CH_LAST       = 4'hB;
  localparam logic [3:0] CH_HALF       = 4'h6;
  localparam logic [3:0] CH_QUARTER    = 4'h3;
  localparam logic [3:0] CH_3QUARTER   = 4'h9;
  localparam logic [5:0] AM_LAST       = 6'h27;        // 40 channel bits
  localparam logic [39:0] AM_PATTERN   = 40'h80_8080_0800; // 1,0x7,1,0x7,1,0x11,1,0x11
  localparam logic [5:0] PREAMB_BITS   = 6'h39;        // nineteen 3T patterns
  localparam logic [1:0] TRI_LAST      = 2'h2;
  localparam int         SYNC_TO_DATA  = 5;            // byte periods
  localparam logic [2:0] PRECOMP_OFF   = 3'h0;

endpackage : rll_endec_pkg
`default_nettype wire

// ### hw/rll_endec_write_and_host_port.sv
`default_nettype none

// Summary of operation
// - Read gate high selects oscillator, drops lock
// - Soft write: mark 7,7,11,11 then 19 3T
// - Zero bytes during preamble; first nonzero syncs
// - Encoded data starts five byte periods later
// - Write output stops within two byte periods
// - Write bytes parity checked, flag until release
// - Sync latch falling edge checks sync parity
// - Parity output muxed by write gate
// - Hard sector: same changeover, no address mark
// - Sync latch transparent only in idle mode
// - Precomp latch transparent while control high
// - Window latch transparent while control high
// - Select bits steer precomp or window shift
// - Pattern based early or late bit shift
// - Address mark found tristate, latched, cleared
// - Byte clock muxed glitch free, oscillator/12
// - Sync found low aligned to next byte
// - Data port direction follows the gates
// - Read parity generated even
module rll_endec_write_and_host_port #(
  parameter int DELAY_BYTES = rll_endec_pkg::SYNC_TO_DATA
) (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_read_gate_n,
  input  wire logic       i_write_gate_n,
  input  wire logic       i_addr_mark_enable_n,
  input  wire logic       i_sync_pattern_latch_n,
  input  wire logic       i_precomp_latch_n,
  input  wire logic       i_window_shift_latch_n,
  input  wire logic       i_shift_sel_bit0_n,
  input  wire logic       i_shift_sel_bit1_n,
  input  wire logic       i_shift_sel_bit2_n,
  input  wire logic       i_window_shift_dir,
  input  wire logic       i_phase_detect_enable,
  input  wire logic       i_hard_sector,
  input  wire logic       i_write_clock,
  input  wire logic       i_ref_oscillator,
  input  wire logic       i_recovered_byte_clock_src,
  input  wire logic       i_recovered_half_clock_src,
  input  wire logic [7:0] i_host_data_bus,
  input  wire logic       i_host_data_parity,
  input  wire logic       i_vco_lock,
  input  wire logic       i_addr_mark_detect,
  input  wire logic [7:0] i_read_byte,
  input  wire logic       i_read_byte_valid,
  output logic [7:0]      o_host_data_bus,
  output logic            o_host_data_parity,
  output logic            o_host_data_oe,
  output logic            o_encoded_write_out,
  output logic            o_precomp_early,
  output logic            o_precomp_late,
  output logic [1:0]      o_precomp_mag,
  output logic [2:0]      o_window_shift_mag,
  output logic            o_window_shift_dir,
  output logic            o_ref_from_oscillator,
  output logic            o_lock,
  output logic            o_byte_clock,
  output logic            o_half_byte_clock,
  output logic            o_sync_found_n,
  output logic            o_addr_mark_found_n,
  output logic            o_addr_mark_found_oe,
  output logic            o_parity_error_flag
);

  // ==========================================================================
  // Functions
  // Even parity over byte and parity bit: high means error
  function automatic logic parity_bad(input rll_endec_pkg::host_word_t w);
    parity_bad = ^{w.parity, w.data};
  endfunction

  // Base 2-to-3 channel map, substitution cases not applied
  function automatic logic [11:0] encode_byte(input logic [7:0] b);
    logic [11:0] c;
    c = '0;
    for (int i = 0; i < 4; i++) begin
      case (b[7-2*i -: 2])
        2'b00:   c[11-3*i -: 3] = 3'b101;
        2'b01:   c[11-3*i -: 3] = 3'b100;
        2'b10:   c[11-3*i -: 3] = 3'b001;
        default: c[11-3*i -: 3] = 3'b010;
      endcase
    end
    encode_byte = c;
  endfunction

  // ==========================================================================
  // Pin synchroniser
  rll_endec_pkg::pin_t pin_meta;
  rll_endec_pkg::pin_t pin;
  rll_endec_pkg::pin_t pin_last;
  rll_endec_pkg::pin_t pin_raw;

  always_comb begin
    pin_raw = '{i_read_gate_n, i_write_gate_n, i_addr_mark_enable_n, i_sync_pattern_latch_n,
                i_precomp_latch_n, i_window_shift_latch_n,
                {i_shift_sel_bit2_n, i_shift_sel_bit1_n, i_shift_sel_bit0_n},
                i_window_shift_dir, i_phase_detect_enable, i_host_data_parity,
                i_host_data_bus, i_write_clock, i_ref_oscillator,
                i_recovered_byte_clock_src, i_recovered_half_clock_src};
  end

  // Two stages, then a copy for edge finding
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta <= rll_endec_pkg::PINS_IDLE;
      pin      <= rll_endec_pkg::PINS_IDLE;
      pin_last <= rll_endec_pkg::PINS_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin      <= pin_meta;
      pin_last <= pin;
    end
  end

  logic osc_rise;
  logic wclk_rise;
  logic sbl_fall;
  logic idle_mode;
  logic write_mode;
  logic read_mode;
  rll_endec_pkg::host_word_t bus_word;

  assign osc_rise   = pin.ref_oscillator & ~pin_last.ref_oscillator;
  assign wclk_rise  = pin.write_clock & ~pin_last.write_clock;
  assign sbl_fall   = ~pin.sync_pattern_latch_n & pin_last.sync_pattern_latch_n;
  assign write_mode = ~pin.write_gate_n;
  assign read_mode  = ~pin.read_gate_n;
  assign idle_mode  = pin.write_gate_n & pin.read_gate_n & pin.addr_mark_enable_n;
  assign bus_word   = '{parity: pin.host_data_parity, data: pin.host_data_bus};

  // ==========================================================================
  // Reference selection and lock
  // Oscillator reference whenever read gate is high or loop is opened
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ref_from_oscillator <= 1'b1;
      o_lock                <= 1'b0;
    end else begin
      o_ref_from_oscillator <= ~read_mode | ~pin.phase_detect_enable;
      o_lock                <= read_mode & (o_lock | i_vco_lock);
    end
  end

  // ==========================================================================
  // Control latches
  logic [1:0]                precomp_sel;
  rll_endec_pkg::shift_cfg_t window_cfg;
  rll_endec_pkg::host_word_t sync_word;

  // Transparent while control high, hold while low
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      precomp_sel <= '0;
      window_cfg  <= '0;
    end else begin
      if (pin.precomp_latch_n)
        precomp_sel <= ~pin.shift_sel_n[1:0];
      if (pin.window_shift_latch_n)
        window_cfg <= '{mag: ~pin.shift_sel_n, dir: pin.window_shift_dir};
    end
  end

  // Sync pattern follows the bus only in idle mode with control high
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      sync_word <= '0;
    else if (idle_mode && pin.sync_pattern_latch_n)
      sync_word <= bus_word;
  end

  // Magnitudes steered by the current mode
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_precomp_mag      <= '0;
      o_window_shift_mag <= '0;
      o_window_shift_dir <= 1'b0;
    end else begin
      o_precomp_mag      <= write_mode ? precomp_sel : 2'h0;
      o_window_shift_mag <= read_mode ? window_cfg.mag : rll_endec_pkg::PRECOMP_OFF;
      o_window_shift_dir <= read_mode & window_cfg.dir;
    end
  end

  // ==========================================================================
  // Parity flags
  logic wr_parity_error_flag;
  logic sb_parity_error_flag;

  // Write flag set per write clock load, cleared by release
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_parity_error_flag <= 1'b0;
      sb_parity_error_flag <= 1'b0;
    end else begin
      if (write_mode && wclk_rise && parity_bad(bus_word))
        wr_parity_error_flag <= 1'b1;
      else if (!write_mode)
        wr_parity_error_flag <= 1'b0;
      if (sbl_fall)
        sb_parity_error_flag <= parity_bad(sync_word);
      else if (pin.sync_pattern_latch_n)
        sb_parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      o_parity_error_flag <= 1'b0;
    else
      o_parity_error_flag <= write_mode ? wr_parity_error_flag : sb_parity_error_flag;
  end

  // ==========================================================================
  // Write byte capture and delay line
  logic [7:0]                  wr_byte;
  logic                        sync_seen;
  rll_endec_pkg::queued_byte_t queue [DELAY_BYTES];
  logic [3:0]                  ch_cnt;
  logic                        byte_tick;
  rll_endec_pkg::wr_state_t    wstate;

  assign byte_tick = osc_rise && (ch_cnt == rll_endec_pkg::CH_LAST);

  // Byte taken on each write clock rise
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_byte   <= '0;
      sync_seen <= 1'b0;
    end else if (wstate == rll_endec_pkg::WR_IDLE) begin
      wr_byte   <= '0;
      sync_seen <= 1'b0;
    end else if (wclk_rise) begin
      wr_byte   <= pin.host_data_bus;
      sync_seen <= sync_seen | (|pin.host_data_bus);
    end
  end

  // One stage per byte period; sync byte emerges after DELAY_BYTES
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < DELAY_BYTES; i++)
        queue[i] <= '0;
    end else if (wstate == rll_endec_pkg::WR_IDLE) begin
      for (int i = 0; i < DELAY_BYTES; i++)
        queue[i] <= '0;
    end else if (byte_tick) begin
      queue[0] <= '{mark: sync_seen, data: wr_byte};
      for (int i = 1; i < DELAY_BYTES; i++)
        queue[i] <= queue[i-1];
    end
  end

  // ==========================================================================
  // Channel bit sequencer, one bit per oscillator rise
  logic [5:0]  pidx;
  logic [1:0]  tri_cnt;
  logic [11:0] shreg;
  logic        ch_bit;
  logic [4:0]  hist;

  // Byte divider: twelve oscillator rises per byte
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      ch_cnt <= '0;
    else if (osc_rise)
      ch_cnt <= byte_tick ? 4'h0 : ch_cnt + 4'h1;
  end

  always_comb begin
    case (wstate)
      rll_endec_pkg::WR_AMARK:  ch_bit = rll_endec_pkg::AM_PATTERN[6'd39 - pidx];
      rll_endec_pkg::WR_PREAMB: ch_bit = (tri_cnt == 2'h0);
      rll_endec_pkg::WR_DATA:   ch_bit = shreg[11];
      default:                  ch_bit = 1'b0;
    endcase
  end

  // Write sequence: wait, mark, preamble, data, stop on release
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wstate  <= rll_endec_pkg::WR_IDLE;
      pidx    <= '0;
      tri_cnt <= '0;
      shreg   <= '0;
    end else begin
      if (osc_rise) begin
        tri_cnt <= (tri_cnt == rll_endec_pkg::TRI_LAST) ? 2'h0 : tri_cnt + 2'h1;
        shreg   <= {shreg[10:0], 1'b0};
        if (pidx != 6'h3F)
          pidx <= pidx + 6'h1;
      end
      case (wstate)
        rll_endec_pkg::WR_IDLE: begin
          if (write_mode)
            wstate <= rll_endec_pkg::WR_WAIT;
        end
        rll_endec_pkg::WR_WAIT: begin
          if (!write_mode)
            wstate <= rll_endec_pkg::WR_IDLE;
          else if (byte_tick && (i_hard_sector || !pin.addr_mark_enable_n)) begin
            wstate  <= i_hard_sector ? rll_endec_pkg::WR_PREAMB
                                     : rll_endec_pkg::WR_AMARK;
            pidx    <= '0;
            tri_cnt <= '0;
          end
        end
        rll_endec_pkg::WR_AMARK: begin
          if (byte_tick && !write_mode)
            wstate <= rll_endec_pkg::WR_IDLE;
          else if (osc_rise && pidx == rll_endec_pkg::AM_LAST) begin
            wstate  <= rll_endec_pkg::WR_PREAMB;
            pidx    <= '0;
            tri_cnt <= '0;
          end
        end
        rll_endec_pkg::WR_PREAMB: begin
          if (byte_tick && !write_mode)
            wstate <= rll_endec_pkg::WR_IDLE;
          else if (byte_tick && pidx >= rll_endec_pkg::PREAMB_BITS
                   && queue[DELAY_BYTES-1].mark) begin
            wstate <= rll_endec_pkg::WR_DATA;
            shreg  <= encode_byte(queue[DELAY_BYTES-1].data);
          end
        end
        rll_endec_pkg::WR_DATA: begin
          if (byte_tick && !write_mode)
            wstate <= rll_endec_pkg::WR_IDLE;
          else if (byte_tick)
            shreg <= encode_byte(queue[DELAY_BYTES-1].data);
        end
        default: wstate <= rll_endec_pkg::WR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Precompensation and write output toggle
  // Centre bit of a five bit window is written, neighbours decide shift
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hist                <= '0;
      o_encoded_write_out <= 1'b0;
      o_precomp_early     <= 1'b0;
      o_precomp_late      <= 1'b0;
    end else if (osc_rise) begin
      hist <= {hist[3:0], ch_bit};
      if (hist[2]) begin
        o_encoded_write_out <= ~o_encoded_write_out;
        o_precomp_early     <= hist[1] | (hist[0] & ~hist[4] & ~hist[3]);
        o_precomp_late      <= hist[3] | (hist[4] & ~hist[0] & ~hist[1]);
      end
    end
  end

  // ==========================================================================
  // Read side: sync detection, data port, parity generation
  logic sync_hit;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_hit          <= 1'b0;
      o_sync_found_n    <= 1'b1;
      o_host_data_bus   <= '0;
      o_host_data_parity<= 1'b0;
    end else if (!read_mode) begin
      sync_hit       <= 1'b0;
      o_sync_found_n <= 1'b1;
    end else if (i_read_byte_valid) begin
      o_host_data_bus    <= i_read_byte;
      o_host_data_parity <= ^i_read_byte;
      if (!sync_hit && i_read_byte == sync_word.data)
        sync_hit <= 1'b1;
      else if (sync_hit)
        o_sync_found_n <= 1'b0;
    end
  end

  // Drive only in read mode; write and sync input otherwise
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      o_host_data_oe <= 1'b0;
    else
      o_host_data_oe <= read_mode & ~write_mode;
  end

  // ==========================================================================
  // Address mark found output
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_addr_mark_found_n  <= 1'b1;
      o_addr_mark_found_oe <= 1'b0;
    end else begin
      o_addr_mark_found_oe <= ~write_mode & ~pin.addr_mark_enable_n;
      if (pin.addr_mark_enable_n)
        o_addr_mark_found_n <= 1'b1;
      else if (i_addr_mark_detect)
        o_addr_mark_found_n <= 1'b0;
    end
  end

  // ==========================================================================
  // Byte and half-byte clock mux
  logic use_read_clk;
  logic osc_byte_clk;
  logic osc_half_clk;

  assign osc_byte_clk = (ch_cnt < rll_endec_pkg::CH_HALF);
  assign osc_half_clk = (ch_cnt < rll_endec_pkg::CH_QUARTER)
                      | ((ch_cnt >= rll_endec_pkg::CH_HALF) && (ch_cnt < rll_endec_pkg::CH_3QUARTER));

  // Source swaps only while both byte clocks are low, so no runt pulse on o_byte_clock
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      use_read_clk      <= 1'b0;
      o_byte_clock      <= 1'b0;
      o_half_byte_clock <= 1'b0;
    end else begin
      if (!osc_byte_clk && !pin.recovered_byte_clock_src)
        use_read_clk <= read_mode & sync_hit;
      o_byte_clock      <= use_read_clk ? pin.recovered_byte_clock_src : osc_byte_clk;
      o_half_byte_clock <= use_read_clk ? pin.recovered_half_clock_src : osc_half_clk;
    end
  end

endmodule // rll_endec_write_and_host_port
`default_nettype wire

// ### tb/rll_endec_write_and_host_port_chk.sv
`default_nettype none
module rll_port_chk (
  input wire logic       i_clock,
  input wire logic       i_arst_n,
  input wire logic       i_read_gate_n,
  input wire logic       i_write_gate_n,
  input wire logic       i_addr_mark_enable_n,
  input wire logic       i_sync_pattern_latch_n,
  input wire logic [7:0] i_host_data_bus,
  input wire logic       i_host_data_parity,
  input wire logic [7:0] o_host_data_bus,
  input wire logic       o_host_data_parity,
  input wire logic       o_host_data_oe,
  input wire logic       o_encoded_write_out,
  input wire logic       o_ref_from_oscillator,
  input wire logic       o_lock,
  input wire logic       o_sync_found_n,
  input wire logic       o_addr_mark_found_n,
  input wire logic       o_addr_mark_found_oe,
  input wire logic       o_parity_error_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic [9:0] quiet;
  // ==========
  // Cycles since the write gate went high
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) quiet <= '0;
    else if (!i_write_gate_n) quiet <= '0;
    else if (quiet != 10'h3FF) quiet <= quiet + 10'h001;
  end
  property p_oe_rd; (!i_read_gate_n && i_write_gate_n)[*5] |-> o_host_data_oe; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("port not driven");
  property p_oe_off; i_read_gate_n[*5] |-> !o_host_data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("port driven");
  property p_ref; i_read_gate_n[*5] |-> o_ref_from_oscillator && !o_lock; endproperty
  a_ref: assert property (p_ref) else $error("reference not restored");
  property p_rpar; o_host_data_oe |-> !(^{o_host_data_bus, o_host_data_parity}); endproperty
  a_rpar: assert property (p_rpar) else $error("read parity odd");
  property p_amf_z; (!i_write_gate_n || i_addr_mark_enable_n)[*5] |-> !o_addr_mark_found_oe;
  endproperty
  a_amf_z: assert property (p_amf_z) else $error("mark found driven");
  property p_amf_clr; i_addr_mark_enable_n[*5] |-> o_addr_mark_found_n; endproperty
  a_amf_clr: assert property (p_amf_clr) else $error("mark found not cleared");
  property p_sbd; i_read_gate_n[*5] |-> o_sync_found_n; endproperty
  a_sbd: assert property (p_sbd) else $error("sync found not cleared");
  property p_quiet; quiet > 10'h180 |-> $stable(o_encoded_write_out); endproperty
  a_quiet: assert property (p_quiet) else $error("write output still moving");
  property p_sb_parity_error_flag;
    (i_write_gate_n && i_read_gate_n && i_sync_pattern_latch_n
      && ^{i_host_data_bus, i_host_data_parity})[*4] ##1
    (i_write_gate_n && !i_sync_pattern_latch_n && ^{i_host_data_bus, i_host_data_parity})[*4]
    |-> ##[1:4] o_parity_error_flag;
  endproperty
  a_sb_parity_error_flag: assert property (p_sb_parity_error_flag) else $error("sync parity missed");
  property p_sb_clr; (i_write_gate_n && i_sync_pattern_latch_n)[*5] |-> !o_parity_error_flag;
  endproperty
  a_sb_clr: assert property (p_sb_clr) else $error("sync flag not cleared");
endmodule : rll_port_chk
bind rll_endec_write_and_host_port rll_port_chk chk_u (.*);
`default_nettype wire

// ### tb/rll_host_model.sv
`default_nettype none
module rll_host_model (
  input  wire logic       i_byte_clock,
  input  wire logic       i_writing,
  input  wire logic [8:0] i_sb_word,
  output logic            o_write_clock,
  output logic [8:0]      o_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] q[$];
  logic [8:0] cur = 9'h000;
  // Write clock looped back from the byte clock
  assign o_write_clock = i_byte_clock;
  // Next byte off the falling edge, zero bytes when none queued
  always @(negedge i_byte_clock) cur <= (q.size() != 0) ? q.pop_front() : 9'h000;
  assign o_word = i_writing ? cur : i_sb_word;
  task automatic push(input logic [8:0] w);
    q.push_back(w);
  endtask
endmodule : rll_host_model
`default_nettype wire

// ### tb/rll_endec_write_and_host_port_tb.sv
`default_nettype none
module rll_endec_write_and_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_arst_n, i_read_gate_n, i_write_gate_n, i_addr_mark_enable_n;
  logic i_sync_pattern_latch_n, i_precomp_latch_n, i_window_shift_latch_n, i_window_shift_dir;
  logic i_shift_sel_bit0_n, i_shift_sel_bit1_n, i_shift_sel_bit2_n, i_phase_detect_enable;
  logic i_hard_sector, i_ref_oscillator, i_recovered_byte_clock_src, i_recovered_half_clock_src;
  logic i_vco_lock, i_addr_mark_detect, i_read_byte_valid, writing;
  logic [7:0] i_read_byte;
  logic [8:0] sb;
  wire logic i_write_clock, i_host_data_parity, o_host_data_parity, o_host_data_oe;
  wire logic [7:0] i_host_data_bus, o_host_data_bus;
  wire logic o_encoded_write_out, o_precomp_early, o_precomp_late, o_window_shift_dir;
  wire logic [1:0] o_precomp_mag;
  wire logic [2:0] o_window_shift_mag;
  wire logic o_ref_from_oscillator, o_lock, o_byte_clock, o_half_byte_clock, o_sync_found_n;
  wire logic o_addr_mark_found_n, o_addr_mark_found_oe, o_parity_error_flag;
  int errors = 0, n_checks = 0, toggles = 0;
  rll_endec_write_and_host_port dut_u (.*);
  rll_host_model ctrl_u (.i_byte_clock(o_byte_clock), .i_writing(writing), .i_sb_word(sb),
    .o_write_clock(i_write_clock), .o_word({i_host_data_parity, i_host_data_bus}));
  // ==========
  // Clocks and write output activity
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    i_ref_oscillator = 1'b0;
    forever #80 i_ref_oscillator = ~i_ref_oscillator;
  end
  always @(o_encoded_write_out) toggles++;
  // ==========
  // Helpers
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic bytes(input int n);
    repeat (n) @(posedge o_byte_clock);
    @(negedge i_clock);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    conclude();
  end
  // ==========
  // Main sequence
  initial begin
    {i_read_gate_n, i_write_gate_n, i_addr_mark_enable_n, i_sync_pattern_latch_n} = 4'hF;
    {i_precomp_latch_n, i_window_shift_latch_n, i_window_shift_dir, i_phase_detect_enable} = 4'hF;
    {i_hard_sector, i_vco_lock, i_addr_mark_detect, i_read_byte_valid, writing} = 5'h00;
    {i_recovered_byte_clock_src, i_recovered_half_clock_src} = 2'h0;
    {i_shift_sel_bit2_n, i_shift_sel_bit1_n, i_shift_sel_bit0_n} = 3'h7;
    i_read_byte = 8'h00;
    sb = 9'h103;
    i_arst_n = 1'b0;
    ticks(4);
    i_arst_n = 1'b1;
    ticks(6);
    check({6'h00, o_ref_from_oscillator, o_sync_found_n, o_addr_mark_found_n}, 9'h007);
    i_sync_pattern_latch_n = 1'b0;
    ticks(8);
    check(9'(o_parity_error_flag), 9'h001);
    i_sync_pattern_latch_n = 1'b1;
    sb = 9'h1A1;
    ticks(8);
    check(9'(o_parity_error_flag), 9'h000);
    {i_shift_sel_bit2_n, i_shift_sel_bit1_n, i_shift_sel_bit0_n} = 3'h5;
    i_window_shift_dir = 1'b0;
    ticks(4);
    {i_sync_pattern_latch_n, i_precomp_latch_n, i_window_shift_latch_n} = 3'h0;
    ticks(6);
    {i_shift_sel_bit2_n, i_shift_sel_bit1_n, i_shift_sel_bit0_n} = 3'h7;
    i_window_shift_dir = 1'b1;
    check({4'h0, o_window_shift_dir, o_window_shift_mag, o_precomp_mag[0]}, 9'h000);
    i_read_gate_n = 1'b0;
    i_vco_lock = 1'b1;
    ticks(6);
    i_vco_lock = 1'b0;
    check({4'h0, o_host_data_oe, o_ref_from_oscillator, o_lock, 2'h0}, 9'h014);
    check({5'h00, o_window_shift_dir, o_window_shift_mag}, 9'h002);
    for (int i = 0; i < 3; i++) begin
      sb = (i == 0) ? 9'h0FF : (i == 1) ? 9'h1A1 : 9'h03C;
      i_read_byte = sb[7:0];
      i_read_byte_valid = 1'b1;
      ticks(1);
      i_read_byte_valid = 1'b0;
      ticks(2);
      check({o_host_data_parity, o_host_data_bus}, sb);
    end
    check(9'(o_sync_found_n), 9'h000);
    i_read_gate_n = 1'b1;
    ticks(6);
    check({6'h00, o_host_data_oe, o_ref_from_oscillator, o_sync_found_n}, 9'h003);
    // Address mark search: found latches low, enable high clears
    i_addr_mark_enable_n = 1'b0;
    ticks(4);
    i_addr_mark_detect = 1'b1;
    ticks(1);
    i_addr_mark_detect = 1'b0;
    ticks(2);
    check({7'h00, o_addr_mark_found_oe, o_addr_mark_found_n}, 9'h002);
    i_addr_mark_enable_n = 1'b1;
    ticks(6);
    for (int h = 0; h < 2; h++) begin
      i_hard_sector = h[0];
      writing = 1'b1;
      bytes(1);
      i_write_gate_n = 1'b0;
      bytes(1);
      i_addr_mark_enable_n = h[0];
      bytes(5);
      check({o_addr_mark_found_oe, 6'h00, o_precomp_mag}, 9'h002);
      toggles = 0;
      bytes(3);
      check(9'(toggles), 9'h00C);
      ctrl_u.push(9'h1A1);
      ctrl_u.push(9'h10F);
      bytes(4);
      check(9'(o_parity_error_flag), 9'h001);
      bytes(3);
      toggles = 0;
      bytes(2);
      check(9'(toggles), 9'h00B);
      bytes(2);
      {i_write_gate_n, i_addr_mark_enable_n, writing} = 3'h6;
      bytes(3);
      check(9'(o_parity_error_flag), 9'h000);
      toggles = 0;
      bytes(2);
      check(9'(toggles), 9'h000);
    end
    conclude();
  end
endmodule : rll_endec_write_and_host_port_tb
`default_nettype wire
